// [rtl/iac_pkg.sv]
// Package for the IP/UDP/ACH header comparator stage.
// Assumes a single analyzer clock and the register port of the stage.
package iac_pkg;

	// Comparator mode codes
	localparam logic [1:0] IAC_MODE_IPV4     = 2'h0;
	localparam logic [1:0] IAC_MODE_IPV6     = 2'h1;
	localparam logic [1:0] IAC_MODE_OTHER32  = 2'h2;
	localparam logic [1:0] IAC_MODE_OTHER128 = 2'h3;

	// Expected version nibbles
	localparam logic [3:0] IAC_VER_IPV4 = 4'h4;
	localparam logic [3:0] IAC_VER_IPV6 = 4'h6;

	// IPv4 flag/fragment bytes within the header
	localparam logic [7:0] IAC_FRAG_BYTE_HI = 8'h06;
	localparam logic [7:0] IAC_FRAG_BYTE_LO = 8'h07;
	localparam int         IAC_MF_BIT       = 5;

	// Per-flow address selection codes
	localparam logic [1:0] IAC_SEL_SRC    = 2'h0;
	localparam logic [1:0] IAC_SEL_DST    = 2'h1;
	localparam logic [1:0] IAC_SEL_EITHER = 2'h2;

	// Next stage codes that are not reserved
	localparam logic [2:0] IAC_NXT_ETH2 = 3'h1;
	localparam logic [2:0] IAC_NXT_IP1  = 3'h2;
	localparam logic [2:0] IAC_NXT_IP2  = 3'h3;
	localparam logic [2:0] IAC_NXT_PTP  = 3'h5;

	// Register byte offsets
	localparam logic [11:0] IAC_REG_MODE      = 12'h000;
	localparam logic [11:0] IAC_REG_PROT_A    = 12'h004;
	localparam logic [11:0] IAC_REG_VAL_B_HI  = 12'h008;
	localparam logic [11:0] IAC_REG_VAL_B_LO  = 12'h00c;
	localparam logic [11:0] IAC_REG_MASK_B_HI = 12'h010;
	localparam logic [11:0] IAC_REG_MASK_B_LO = 12'h014;
	localparam logic [11:0] IAC_REG_POS_B     = 12'h018;
	localparam logic [11:0] IAC_REG_NEXT      = 12'h01c;
	localparam logic [11:0] IAC_REG_FLOW_POS  = 12'h020;
	localparam logic [11:0] IAC_REG_SUM       = 12'h024;
	localparam logic [11:0] IAC_REG_STATUS    = 12'h028;
	// Flow block: region bits [11:10], flow index [9:6], word [5:2]
	localparam logic [1:0]  IAC_FLOW_REGION   = 2'h1;
	localparam logic [3:0]  IAC_FW_CTRL       = 4'h0;
	localparam logic [3:0]  IAC_FW_VAL0       = 4'h1;
	localparam logic [3:0]  IAC_FW_MASK0      = 4'h5;

	// Reset values
	localparam logic [1:0] IAC_RST_MODE    = 2'h0;
	localparam logic [1:0] IAC_RST_SUM_LEN = 2'h2;

	// Result handed to the next stage
	typedef struct packed {
		logic       proto_ok;
		logic       next_stage_ok;
		logic [2:0] next_stage;
		logic [7:0] next_offset;
		logic       sum_zero;
		logic       sum_fixup;
		logic [7:0] sum_location;
		logic [1:0] sum_length;
	} iac_result_s;

endpackage

// [rtl/iac_comparator.sv]
// IP/UDP/ACH header comparator stage with register port and flow table.
// Assumes header bytes arrive in order, first byte flagged, last flagged.
`timescale 1ns/100ps

// Overview of operation
// (RULE1) Mode code picks IPv4, IPv6, other 32-bit or other 128-bit.
// (RULE2) IPv4 needs version 4, IPv6 needs version 6, else protocol fails.
// (RULE3) Other-protocol modes skip the version check.
// (RULE4) IPv4 rejects nonzero fragment offset or set more-fragments flag.
// (RULE5) Match set A compares one masked byte, protocol or next header.
// (RULE6) Mask bit one counts, zero ignores; all-zero mask always passes.
// (RULE7) Match set A sits at a 5-bit byte offset from header start.
// (RULE8) Match set B compares 64 masked bits at a 7-bit byte offset.
// (RULE9) Next header start is the programmed 8-bit byte count, not computed.
// (RULE10) Software keeps one encapsulation order and header length per engine.
// (RULE11) 3-bit next stage pointer; codes 0, 4, 6, 7 are reserved.
// (RULE12) Flow field starts at a 5-bit byte offset, source address for IP.
// (RULE13) Checksum clear zeroes the 2-byte UDP checksum, IPv4 only.
// (RULE14) Checksum update fixes the last two UDP bytes for IPv6.
// (RULE15) Software never sets checksum clear and update together.
// (RULE16) IPv4 checksum location offset is forwarded toward the rewriter.
// (RULE17) 2-bit checksum length in bytes, normally two.
// (RULE18) IP modes match each flow on source or destination address.
// (RULE19) Other modes match a masked 32 or 128-bit field, no src/dst.
// (RULE20) Per-flow select: 0 source, 1 destination, 2 either.
// (RULE21) IPv6 uses all 128 bits, IPv4 only the upper 32 bits.
// (RULE22) Disabled flow never reports a match.
// (RULE23) Result gives protocol valid, flow hits, next offset and stage.
module iac_comparator
	import iac_pkg::*;
#(
	parameter int NF = 8
)(
	input  wire logic          clock,        // 50 MHz clock
	input  wire logic          rst_b,        // Async reset, active low
	input  wire logic [11:0]   reg_addr,     // Register byte address
	input  wire logic [31:0]   reg_wdata,    // Register write data
	input  wire logic          reg_wr,       // Write strobe
	input  wire logic          reg_rd,       // Read strobe
	output logic      [31:0]   reg_rdata,    // Read data, cycle after read
	input  wire logic          in_valid,     // Header byte valid
	input  wire logic          in_first,     // First byte of this header
	input  wire logic          in_last,      // Last byte of the frame part
	input  wire logic [7:0]    in_data,      // Header byte
	output logic               res_valid,    // Result pulse
	output iac_result_s        res_info,     // Result for next stage
	output logic      [NF-1:0] res_flow_hit  // Per-flow match vector
);

	// Configuration registers
	logic [1:0]  mode_select;
	logic [7:0]  val_a;
	logic [7:0]  mask_a;
	logic [4:0]  pos_a;
	logic [63:0] val_b;
	logic [63:0] mask_b;
	logic [6:0]  pos_b;
	logic [7:0]  next_off;
	logic [2:0]  next_sel;
	logic [4:0]  flow_pos;
	logic        sum_zero_en;
	logic        sum_fixup_en;
	logic [7:0]  sum_loc;
	logic [1:0]  sum_len;

	// Capture state
	logic [7:0]  idx;
	logic [3:0]  ver_nib;
	logic        frag_bad;
	logic        a_seen;
	logic        a_match;
	logic [63:0] b_sh;
	logic [3:0]  b_cnt;
	logic        done_p;
	logic [7:0]  fb [32];
	logic [255:0] fvec;

	// Register decode
	wire         g_wr     = reg_wr & (reg_addr[11:10] == 2'h0);
	wire         f_region = reg_addr[11:10] == IAC_FLOW_REGION;
	wire  [3:0]  f_idx    = reg_addr[9:6];
	wire  [3:0]  f_word   = reg_addr[5:2];

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_select  <= IAC_RST_MODE;
			{val_a, mask_a, pos_a} <= '0;
			{val_b, mask_b, pos_b} <= '0;
			{next_off, next_sel, flow_pos} <= '0;
			{sum_zero_en, sum_fixup_en, sum_loc} <= '0;
			sum_len      <= IAC_RST_SUM_LEN;
		end
		else if (g_wr)
		begin
			unique case (reg_addr)
				IAC_REG_MODE:      mode_select <= reg_wdata[1:0];
				IAC_REG_PROT_A:
				begin
					val_a  <= reg_wdata[7:0];
					mask_a <= reg_wdata[15:8];
					pos_a  <= reg_wdata[20:16];
				end
				IAC_REG_VAL_B_HI:  val_b[63:32]  <= reg_wdata;
				IAC_REG_VAL_B_LO:  val_b[31:0]   <= reg_wdata;
				IAC_REG_MASK_B_HI: mask_b[63:32] <= reg_wdata;
				IAC_REG_MASK_B_LO: mask_b[31:0]  <= reg_wdata;
				IAC_REG_POS_B:     pos_b <= reg_wdata[6:0];
				IAC_REG_NEXT:
				begin
					next_off <= reg_wdata[7:0];
					next_sel <= reg_wdata[10:8];
				end
				IAC_REG_FLOW_POS:  flow_pos <= reg_wdata[4:0];
				IAC_REG_SUM:
				begin
					sum_zero_en  <= reg_wdata[0];
					sum_fixup_en <= reg_wdata[1];
					sum_len      <= reg_wdata[3:2];
					sum_loc      <= reg_wdata[15:8];
				end
				default: ;
			endcase
		end
	end

	// Byte position and captures
	wire  [7:0] pos    = in_first ? 8'h00 : idx;
	wire  [7:0] b_k    = pos - {1'b0, pos_b};
	wire  [7:0] f_k    = pos - {3'h0, flow_pos};
	wire        a_take = in_valid & (pos == {3'h0, pos_a});       // RULE7
	wire        b_take = in_valid & (pos >= {1'b0, pos_b})
	                     & (b_k < 8'h08);                         // RULE8
	wire        f_take = in_valid & (pos >= {3'h0, flow_pos})
	                     & (f_k < 8'h20);                         // RULE12
	wire        frag_t = in_valid & (((pos == IAC_FRAG_BYTE_HI)
	                     & (in_data[IAC_MF_BIT] | (|in_data[4:0])))
	                     | ((pos == IAC_FRAG_BYTE_LO) & (|in_data)));
	wire  [7:0] next_idx = (pos == 8'hff) ? pos : pos + 8'h01;
	wire  [3:0] b_base   = in_first ? 4'h0 : b_cnt;
	wire        a_hit_now = ((in_data ^ val_a) & mask_a) == 8'h00; // RULE5

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{idx, ver_nib, frag_bad, a_seen, a_match} <= '0;
			{b_sh, b_cnt, done_p} <= '0;
		end
		else
		begin
			done_p <= in_valid & in_last;
			if (in_valid)
			begin
				idx      <= next_idx;
				frag_bad <= (in_first ? 1'b0 : frag_bad) | frag_t; // RULE4
				a_seen   <= (in_first ? 1'b0 : a_seen) | a_take;
				b_cnt    <= b_base + {3'h0, b_take};
			end
			if (in_valid & (pos == 8'h00))
				ver_nib <= in_data[7:4];
			if (a_take)
				a_match <= a_hit_now;
			if (b_take)
				b_sh <= {b_sh[55:0], in_data};
		end
	end

	// Flow field bytes
	genvar j;
	generate
		for (j = 0; j < 32; j++)
		begin : g_fb
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
					fb[j] <= 8'h00;
				else if (f_take & (f_k[4:0] == 5'(j)))
					fb[j] <= in_data;
			end
			assign fvec[255-8*j -: 8] = fb[j];
		end
	endgenerate

	// Protocol evaluation
	wire comparator_mode_select   = ~mode_select[1];                            // RULE1
	wire wide_mode = (mode_select == IAC_MODE_IPV6)
	                 | (mode_select == IAC_MODE_OTHER128);
	wire ver_pass  = mode_select[1] |                            // RULE3
	                 ((mode_select == IAC_MODE_IPV4) ?
	                  (ver_nib == IAC_VER_IPV4) :
	                  (ver_nib == IAC_VER_IPV6));                // RULE2
	wire frag_pass = (mode_select != IAC_MODE_IPV4) | ~frag_bad;  // RULE4
	wire a_pass    = (mask_a == 8'h00) | (a_seen & a_match);      // RULE6
	wire b_pass    = (mask_b == 64'h0) | ((b_cnt == 4'h8)
	                 & (((b_sh ^ val_b) & mask_b) == 64'h0));    // RULE6
	wire proto_ok  = ver_pass & frag_pass & a_pass & b_pass;
	wire stage_ok  = (next_sel == IAC_NXT_ETH2) | (next_sel == IAC_NXT_IP1)
	                 | (next_sel == IAC_NXT_IP2)
	                 | (next_sel == IAC_NXT_PTP);                // RULE11

	// Address fields; IPv4 and 32-bit fields sit in the upper word
	wire [127:0] src_f = wide_mode ? fvec[255:128]
	                     : {fvec[255:224], 96'h0};               // RULE21
	wire [127:0] dst_f = wide_mode ? fvec[127:0]
	                     : {fvec[223:192], 96'h0};               // RULE18

	// Flow table
	logic [NF-1:0] flow_active;
	logic [1:0]    flow_sel [NF];
	logic [NF-1:0] flow_now;
	logic [NF-1:0] src_ok;
	logic [31:0]   flow_rd [NF];

	genvar f;
	generate
		for (f = 0; f < NF; f++)
		begin : g_flow
			logic [127:0] fval;
			logic [127:0] fmask;
			wire          sel_me = reg_wr & f_region & (f_idx == 4'(f));
			wire [127:0]  m_eff  = wide_mode ? fmask
			                       : {fmask[127:96], 96'h0};     // RULE21
			wire          s_ok   = ((src_f ^ fval) & m_eff) == 128'h0;
			wire          d_ok   = ((dst_f ^ fval) & m_eff) == 128'h0;
			wire          ip_hit = (flow_sel[f] == IAC_SEL_SRC) ? s_ok :
			                       (flow_sel[f] == IAC_SEL_DST) ? d_ok :
			                       (flow_sel[f] == IAC_SEL_EITHER) ?
			                       (s_ok | d_ok) : 1'b0;         // RULE20
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					flow_active[f] <= 1'b0;
					flow_sel[f]    <= IAC_SEL_SRC;
					fval           <= '0;
					fmask          <= '0;
				end
				else if (sel_me)
				begin
					if (f_word == IAC_FW_CTRL)
					begin
						flow_active[f] <= reg_wdata[0];
						flow_sel[f]    <= reg_wdata[2:1];
					end
					for (int w = 0; w < 4; w++)
					begin
						if (f_word == IAC_FW_VAL0 + 4'(w))
							fval[127-32*w -: 32] <= reg_wdata;
						if (f_word == IAC_FW_MASK0 + 4'(w))
							fmask[127-32*w -: 32] <= reg_wdata;
					end
				end
			end
			assign src_ok[f]   = s_ok;
			assign flow_now[f] = flow_active[f] &                // RULE22
			                     (comparator_mode_select ? ip_hit : s_ok);     // RULE19
			always_comb
			begin
				flow_rd[f] = 32'h0;
				if (f_word == IAC_FW_CTRL)
					flow_rd[f] = {29'h0, flow_sel[f], flow_active[f]};
				for (int w = 0; w < 4; w++)
				begin
					if (f_word == IAC_FW_VAL0 + 4'(w))
						flow_rd[f] = fval[127-32*w -: 32];
					if (f_word == IAC_FW_MASK0 + 4'(w))
						flow_rd[f] = fmask[127-32*w -: 32];
				end
			end
		end
	endgenerate

	// Result toward the next stage
	iac_result_s next_res;
	always_comb
	begin
		next_res               = '0;
		next_res.proto_ok      = proto_ok;
		next_res.next_stage_ok = stage_ok;
		next_res.next_stage    = next_sel;                       // RULE11
		next_res.next_offset   = next_off;                       // RULE9
		next_res.sum_zero      = sum_zero_en &
		                         (mode_select == IAC_MODE_IPV4);  // RULE13
		next_res.sum_fixup     = sum_fixup_en & ~sum_zero_en &
		                         (mode_select == IAC_MODE_IPV6);  // RULE14
		next_res.sum_location  = (mode_select == IAC_MODE_IPV4) ?
		                         sum_loc : 8'h00;                // RULE16
		next_res.sum_length    = sum_len;                        // RULE17
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			res_valid    <= 1'b0;
			res_info     <= '0;
			res_flow_hit <= '0;
		end
		else
		begin
			res_valid <= done_p;                                 // RULE23
			if (done_p)
			begin
				res_info     <= next_res;
				res_flow_hit <= flow_now;
			end
		end
	end

	// Read path
	logic [31:0] g_rd;
	wire  [31:0] status_w = {{(16-NF){1'b0}}, res_flow_hit,
	                         14'h0, res_info.next_stage_ok,
	                         res_info.proto_ok};
	always_comb
	begin
		unique case (reg_addr)
			IAC_REG_MODE:      g_rd = {30'h0, mode_select};
			IAC_REG_PROT_A:    g_rd = {11'h0, pos_a, mask_a, val_a};
			IAC_REG_VAL_B_HI:  g_rd = val_b[63:32];
			IAC_REG_VAL_B_LO:  g_rd = val_b[31:0];
			IAC_REG_MASK_B_HI: g_rd = mask_b[63:32];
			IAC_REG_MASK_B_LO: g_rd = mask_b[31:0];
			IAC_REG_POS_B:     g_rd = {25'h0, pos_b};
			IAC_REG_NEXT:      g_rd = {21'h0, next_sel, next_off};
			IAC_REG_FLOW_POS:  g_rd = {27'h0, flow_pos};
			IAC_REG_SUM:       g_rd = {16'h0, sum_loc, 4'h0, sum_len,
			                           sum_fixup_en, sum_zero_en};
			IAC_REG_STATUS:    g_rd = status_w;
			default:           g_rd = 32'h0;
		endcase
	end
	wire        f_here  = f_region & ({1'b0, f_idx} < 5'(NF));
	wire [31:0] rd_word = f_here ? flow_rd[f_idx[$clog2(NF)-1:0]]
	                      : (reg_addr[11:10] == 2'h0) ? g_rd : 32'h0;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? rd_word : 32'h0;
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	version_check_a: assert property (done_p && !mode_select[1] &&     // RULE2
		ver_nib != ((mode_select == IAC_MODE_IPV4) ? 4'h4 : 4'h6)
		|=> !res_info.proto_ok)
		else $error("Bad version accepted");
	other_skip_a: assert property (done_p && mode_select[1] && a_pass // RULE3
		&& b_pass |=> res_info.proto_ok)
		else $error("Other mode rejected despite passing sets");
	frag_reject_a: assert property (done_p && frag_bad &&             // RULE4
		mode_select == IAC_MODE_IPV4 |=> !res_info.proto_ok)
		else $error("Fragment accepted in IPv4");
	mask_off_a: assert property (done_p && mask_a == 8'h00 &&         // RULE6
		mask_b == 64'h0 && ver_pass && frag_pass |=> res_info.proto_ok)
		else $error("Disabled sets blocked the header");
	stage_code_a: assert property (done_p |=> res_info.next_stage_ok   // RULE11
		== ($past(next_sel) inside {3'h1, 3'h2, 3'h3, 3'h5}))
		else $error("Next stage validity wrong");
	sum_zero_v4_a: assert property (res_valid && res_info.sum_zero    // RULE13
		|-> $past(mode_select) == IAC_MODE_IPV4)
		else $error("Checksum clear outside IPv4");
	flow_off_a: assert property (done_p && !flow_active[0]            // RULE22
		|=> !res_flow_hit[0])
		else $error("Disabled flow matched");
	src_only_a: assert property (done_p && comparator_mode_select && !src_ok[0] &&   // RULE20
		flow_sel[0] == IAC_SEL_SRC |=> !res_flow_hit[0])
		else $error("Source-only flow matched wrong address");
	result_time_a: assert property (in_valid && in_last              // RULE23
		|-> ##2 res_valid)
		else $error("Result not produced two cycles after last byte");

	ok_cov: cover property (res_valid && res_info.proto_ok);
	hit_cov: cover property (res_valid && res_flow_hit != '0);
	v6_cov: cover property (done_p && mode_select == IAC_MODE_IPV6);
	other_cov: cover property (done_p && mode_select[1] && proto_ok);

endmodule

// [tb/iac_upstream_model.sv]
// Upstream stage model that streams one header into the comparator.
// Assumes the bench calls send; the stage has no backpressure.
`timescale 1ns/100ps
module iac_upstream_model
(
	input  wire logic clock,    // Stage clock
	output logic      in_valid, // Byte valid
	output logic      in_first, // First byte of header
	output logic      in_last,  // Last byte of header
	output logic [7:0] in_data  // Header byte
);
	initial
	begin
		in_valid = 1'b0;
		in_first = 1'b0;
		in_last  = 1'b0;
		in_data  = 8'h5a;
	end

	// Idle bits insert empty cycles, data toggles so no stale byte shows
	task automatic send(input logic [7:0] hdr[$], input logic [31:0] idle);
		for (int i = 0; i < hdr.size(); i++)
		begin
			if (idle[i % 32])
			begin
				@(posedge clock);
				in_valid <= 1'b0;
				in_data  <= ~in_data;
			end
			@(posedge clock);
			in_valid <= 1'b1;
			in_first <= (i == 0);
			in_last  <= (i == hdr.size() - 1);
			in_data  <= hdr[i];
		end
		@(posedge clock);
		in_valid <= 1'b0;
		in_first <= 1'b0;
		in_last  <= 1'b0;
		in_data  <= ~in_data;
	endtask
endmodule

// [tb/iac_comparator_tb.sv]
// Self-checking bench for the header comparator stage.
// Assumes iac_pkg and the upstream model file are compiled first.
`timescale 1ns/100ps
module iac_comparator_tb;
	import iac_pkg::*;
	localparam int NF = 2;
	logic          clock, rst_b, reg_wr, reg_rd, res_valid;
	logic          in_valid, in_first, in_last, zr, fx;
	logic [11:0]   reg_addr;
	logic [31:0]   reg_wdata, reg_rdata;
	logic [7:0]    in_data, va, ma, nxo, loc;
	iac_result_s   res_info;
	logic [NF-1:0] res_flow_hit;
	int            num_errors = 0;
	int            checks_done = 0;
	integer        seed = 32'h8d735a74;
	logic [4:0]    pa, fp;
	logic [63:0]   vb, mb;
	logic [6:0]    pb;
	logic [2:0]    nst;
	logic [1:0]    mode, slen;
	logic          act [NF];
	logic [1:0]    sel [NF];
	logic [127:0]  fv [NF];
	logic [127:0]  fm [NF];
	logic [7:0]    hdr [$];

	iac_comparator #(.NF(NF)) iac_comparator_i (.clock(clock),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.in_valid(in_valid), .in_first(in_first), .in_last(in_last),
		.in_data(in_data), .res_valid(res_valid), .res_info(res_info),
		.res_flow_hit(res_flow_hit));
	iac_upstream_model iac_upstream_model_i (.clock(clock),
		.in_valid(in_valid), .in_first(in_first), .in_last(in_last),
		.in_data(in_data));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [127:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
		input string what);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check(what, 128'(reg_rdata), 128'(e));
	endtask

	function automatic logic [11:0] faddr(input int f, input logic [3:0] w);
		return {IAC_FLOW_REGION, 4'(f), w, 2'b00};
	endfunction

	// Header bytes from p, first byte in the top bits
	function automatic logic [127:0] field(input int p, input int n);
		logic [127:0] v;
		v = '0;
		for (int i = 0; i < n; i++)
			v[127 - 8*i -: 8] = hdr[p + i];
		return v;
	endfunction

	function automatic logic exp_proto();
		logic ok;
		ok = ((va ^ hdr[pa]) & ma) == 8'h00;
		ok &= (({vb, 64'h0} ^ field(pb, 8)) & {mb, 64'h0}) == 128'h0;
		if (mode == IAC_MODE_IPV4)
			ok &= hdr[0][7:4] == IAC_VER_IPV4 && hdr[6][4:0] == 5'h00
				&& hdr[7] == 8'h00 && !hdr[6][IAC_MF_BIT];
		if (mode == IAC_MODE_IPV6)
			ok &= hdr[0][7:4] == IAC_VER_IPV6;
		return ok;
	endfunction

	function automatic logic exp_hit(input int f);
		logic [127:0] w;
		logic s, d;
		w = mode[0] ? '1 : {32'hffffffff, 96'h0};
		s = ((field(fp, 16) ^ fv[f]) & fm[f] & w) == 128'h0;
		d = ((field(fp + (mode[0] ? 16 : 4), 16) ^ fv[f]) & fm[f] & w) == 0;
		if (!act[f])
			return 1'b0;
		if (mode[1])
			return s;
		return (sel[f] == IAC_SEL_SRC && s) || (sel[f] == IAC_SEL_DST && d)
			|| (sel[f] == IAC_SEL_EITHER && (s || d));
	endfunction

	task automatic configure();
		wr(IAC_REG_MODE, {30'h0, mode});
		wr(IAC_REG_PROT_A, {11'h0, pa, ma, va});
		wr(IAC_REG_VAL_B_HI, vb[63:32]);
		wr(IAC_REG_VAL_B_LO, vb[31:0]);
		wr(IAC_REG_MASK_B_HI, mb[63:32]);
		wr(IAC_REG_MASK_B_LO, mb[31:0]);
		wr(IAC_REG_POS_B, {25'h0, pb});
		wr(IAC_REG_NEXT, {21'h0, nst, nxo});
		wr(IAC_REG_FLOW_POS, {27'h0, fp});
		wr(IAC_REG_SUM, {16'h0, loc, 4'h0, slen, fx, zr});
		for (int f = 0; f < NF; f++)
		begin
			wr(faddr(f, IAC_FW_CTRL), {29'h0, sel[f], act[f]});
			for (int w = 0; w < 4; w++)
			begin
				wr(faddr(f, IAC_FW_VAL0 + 4'(w)), fv[f][127 - 32*w -: 32]);
				wr(faddr(f, IAC_FW_MASK0 + 4'(w)), fm[f][127 - 32*w -: 32]);
			end
		end
	endtask

	initial
	begin
		logic [31:0] r;
		logic [127:0] t128;
		iac_result_s e;
		logic [NF-1:0] h;
		int n;
		{reg_wr, reg_rd, reg_addr, reg_wdata, rst_b} = '0;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		check("reset result", 128'(res_info), 128'h0);
		rd_chk(IAC_REG_MODE, 32'h0, "mode reset");
		rd_chk(IAC_REG_SUM, 32'h8, "sum reset");
		wr(IAC_REG_STATUS, 32'hffffffff);
		rd_chk(IAC_REG_STATUS, 32'h0, "status");
		wr(faddr(NF, IAC_FW_CTRL), 32'h7);
		rd_chk(faddr(NF, IAC_FW_CTRL), 32'h0, "flow beyond");
		rd_chk(12'h02c, 32'h0, "unmapped");
		$display("test registers at reset done");
		for (int t = 0; t < 48; t++)
		begin
			r = $random(seed);
			mode = 2'(t);
			hdr.delete();
			for (int i = 0; i < 72; i++)
				hdr.push_back(8'($random(seed)));
			if (($random(seed) & 3) != 0)
				hdr[0][7:4] = mode[0] ? IAC_VER_IPV6 : IAC_VER_IPV4;
			if (($random(seed) & 3) != 0)
				{hdr[6][5:0], hdr[7]} = 14'h0;
			if (t % 8 == 4)
				hdr[6][IAC_MF_BIT] = 1'b1;
			pa = 5'($random(seed));
			ma = r[0] ? 8'h00 : 8'($random(seed));
			va = hdr[pa] ^ (r[1] ? 8'h01 << r[6:4] : 8'h00);
			pb = 7'($random(seed)) & 7'h3f;
			t128 = field(pb, 8);
			mb = r[2] ? 64'h0 : {$random(seed), $random(seed)};
			vb = t128[127:64] ^ (r[3] ? 64'h1 << r[13:8] : 64'h0);
			nxo = 8'($random(seed));
			nst = 3'(t >> 2);
			fp = 5'($random(seed));
			zr = r[16];
			fx = r[17] & !r[16];
			loc = 8'($random(seed));
			slen = r[19:18];
			for (int f = 0; f < NF; f++)
			begin
				act[f] = r[20 + f] | r[22];
				sel[f] = r[24 + 2*f +: 2];
				fm[f] = r[26 + f] ? '1 : {4{$random(seed)}};
				fv[f] = field(fp + ((sel[f] == IAC_SEL_DST) ?
					(mode[0] ? 16 : 4) : 0), 16)
					^ (r[10 + f] ? 128'h1 << r[15:9] : 128'h0);
			end
			configure();
			if (t == 1)
			begin
				rd_chk(IAC_REG_PROT_A, {11'h0, pa, ma, va}, "match a");
				rd_chk(IAC_REG_NEXT, {21'h0, nst, nxo}, "next");
				rd_chk(faddr(1, IAC_FW_MASK0), fm[1][127:96], "mask");
			end
			iac_upstream_model_i.send(hdr, t[0] ? r : 32'h0);
			n = 0;
			do
			begin
				@(posedge clock);
				#1;
				n++;
			end
			while (res_valid !== 1'b1 && n < 20);
			if (n == 20)
			begin
				num_errors++;
				conclude();
			end
			// Send returns at the edge taking the last byte
			check("latency", 128'(n), 128'd1);
			e = '0;
			e.proto_ok = exp_proto();
			e.next_stage_ok = nst inside {IAC_NXT_ETH2, IAC_NXT_IP1,
				IAC_NXT_IP2, IAC_NXT_PTP};
			e.next_stage = nst;
			e.next_offset = nxo;
			e.sum_zero = zr && mode == IAC_MODE_IPV4;
			e.sum_fixup = fx && !zr && mode == IAC_MODE_IPV6;
			e.sum_location = (mode == IAC_MODE_IPV4) ? loc : 8'h00;
			e.sum_length = slen;
			for (int f = 0; f < NF; f++)
				h[f] = exp_hit(f);
			check("proto", 128'(res_info.proto_ok),
				128'(e.proto_ok));
			check("result", 128'(res_info),
				128'(e));
			check("hits", 128'(res_flow_hit),
				128'(h));
			@(posedge clock);
			#1;
			check("pulse", 128'(res_valid), 128'h0);
			rd_chk(IAC_REG_STATUS, {16'(h), 14'h0, e.next_stage_ok,
				e.proto_ok}, "status");
			$display("test header %0d mode %0d done", t, mode);
		end
		conclude();
	end
endmodule
